/* dcf_regs.svh */
// register map, field positions and reset values of the 9-bit flag buffer
// assumes a 32-bit bus slave decoding the low address byte
`ifndef DCF_REGS_SVH
`define DCF_REGS_SVH

`define DCF_ADDR_AE_OFS 8'h00
`define DCF_ADDR_AF_OFS 8'h04
`define DCF_ADDR_LEVEL 8'h08
`define DCF_ADDR_FLAGS 8'h0C
`define DCF_ADDR_IRQ_STAT 8'h10
`define DCF_ADDR_IRQ_MASK 8'h14

`define DCF_HSIZE_WORD 3'h2
`define DCF_DEPTH_DEFAULT 16384
`define DCF_OFS_DEFAULT 32'h0000_0007

`define DCF_FLG_EMPTY_N 0
`define DCF_FLG_FULL_N 1
`define DCF_FLG_AE_N 2
`define DCF_FLG_AF_N 3
`define DCF_FLG_MODE 4

`define DCF_EV_OVERFLOW 0
`define DCF_EV_UNDERFLOW 1
`define DCF_EV_ALMOST_FULL 2
`define DCF_EV_ALMOST_EMPTY 3
`define DCF_NUM_EV 4

`define DCF_PIN_W 17

`endif

/* dcf_pkg.sv */
// shared types of the 9-bit flag buffer
// assumes nothing beyond a SystemVerilog compiler
package dcf_pkg;
    typedef logic [8:0] dcf_word_t;
    typedef enum logic {
        DCF_MODE_DUAL_WE,
        DCF_MODE_OFS_LOAD
    } dcf_wmode_t;
endpackage

/* dcf_pin_sync.sv */
// two-stage synchroniser for a group of asynchronous pins
// assumes pins are slower than the local clock; one flop pair per bit
`timescale 1ns/1ps
module dcf_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta;

    genvar b;
    generate
        for (b = 0; b < W; b++) begin : g_bit
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    meta[b] <= RST_VAL[b];
                    sync_o[b] <= RST_VAL[b];
                end else begin
                    meta[b] <= pin_i[b];
                    sync_o[b] <= meta[b];
                end
            end
        end
    endgenerate
endmodule // dcf_pin_sync

/* dcf_top.sv */
// 9-bit first-in first-out buffer with pin flags and a register slave
// assumes pin clocks and enables are asynchronous and slower than
// REF_CLK_I: each pin clock phase must last at least two REF_CLK_I cycles
//
// What this block does
// RQ1 - write when enable a low, b high
// RQ2 - back-to-back writes on every write clock
// RQ3 - nine-bit words in and out
// RQ4 - read when both read enables low
// RQ5 - shared or independent clocks, simultaneous access
// RQ6 - empty, full, almost-empty, almost-full outputs
// RQ7 - thresholds settable to any single word
// RQ8 - default thresholds empty+7 and full-7
// RQ9 - empty flags move on read clock only
// RQ10 - full flags move on write clock only
// RQ11 - flags hold at least one cycle
// RQ12 - expansion logic drives one enable per port; this block holds no expansion logic
// RQ13 - slices side by side for wider words
// RQ14 - writes ignored while full flag low
// RQ15 - reads ignored while empty flag low
// RQ16 - reset pin empties buffer before use
// RQ17 - enable b sampled at reset picks mode
// RQ18 - depth parameter, all flags active low
// RQ19 - output enable gates data outputs
`timescale 1ns/1ps
`include "dcf_regs.svh"
module dcf_top
    import dcf_pkg::*;
#(
    parameter int DEPTH = `DCF_DEPTH_DEFAULT
) (
    input wire logic REF_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    output logic IRQ_O,
    input wire logic WRITE_CLK_I,
    input wire logic READ_CLK_I,
    input wire logic [8:0] DATA_I,
    input wire logic WRITE_ENABLE_A_N_I,
    input wire logic WRITE_ENABLE_B_OR_OFFSET_LOAD_I,
    input wire logic READ_ENABLE_A_N_I,
    input wire logic READ_ENABLE_B_N_I,
    input wire logic BUFFER_RESET_N_I,
    input wire logic OUTPUT_ENABLE_N_I,
    output logic [8:0] DATA_O,
    output logic DATA_OE_O,
    output logic EMPTY_FLAG_N_O,
    output logic FULL_FLAG_N_O,
    output logic ALMOST_EMPTY_FLAG_N_O,
    output logic ALMOST_FULL_FLAG_N_O
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] OFS_RESET = AW'(`DCF_OFS_DEFAULT);
    // inactive levels so a system reset looks like idle pins
    localparam logic [`DCF_PIN_W-1:0] PIN_IDLE = {
        1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 9'h000};

    // pin synchronisation: clocks, enables and data share one delay
    logic [`DCF_PIN_W-1:0] pin_s;

    dcf_pin_sync #(
        .W(`DCF_PIN_W),
        .RST_VAL(PIN_IDLE)
    ) u_pin_sync (
        .clk_i(REF_CLK_I),
        .rst_i(SYS_RST_I),
        .pin_i({OUTPUT_ENABLE_N_I, BUFFER_RESET_N_I, READ_ENABLE_B_N_I,
                READ_ENABLE_A_N_I, WRITE_ENABLE_B_OR_OFFSET_LOAD_I,
                WRITE_ENABLE_A_N_I, READ_CLK_I, WRITE_CLK_I, DATA_I}),
        .sync_o(pin_s)
    );

    wire dcf_word_t data_s = pin_s[8:0];
    wire wclk_s = pin_s[9];
    wire rclk_s = pin_s[10];
    wire wen_a_n_s = pin_s[11];
    wire wen_b_s = pin_s[12];
    wire ren_a_n_s = pin_s[13];
    wire ren_b_n_s = pin_s[14];
    wire buf_rst_s = ~pin_s[15];
    wire oe_n_s = pin_s[16];

    logic wclk_d;
    logic rclk_d;
    dcf_wmode_t mode;
    dcf_word_t mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW-1:0] ae_ofs;
    logic [AW-1:0] af_ofs;
    logic [`DCF_NUM_EV-1:0] irq_stat;
    logic [`DCF_NUM_EV-1:0] irq_mask;
    logic dp_write;
    logic [7:0] dp_addr;

    // pin clock edges become one-cycle enables
    wire wr_edge = wclk_s & ~wclk_d;
    wire rd_edge = rclk_s & ~rclk_d;

    wire wr_req = wr_edge & ~wen_a_n_s & wen_b_s; // RQ1
    wire rd_req = rd_edge & ~ren_a_n_s & ~ren_b_n_s; // RQ4
    // the registered full flag gates writes, so space freed by a read
    // is only offered to the writer after the next write clock edge has raised the full flag
    wire wr_do = wr_req & FULL_FLAG_N_O & ~buf_rst_s; // RQ14
    // likewise a word written into an empty buffer becomes readable
    // only once a read clock edge has raised the empty flag
    wire rd_do = rd_req & EMPTY_FLAG_N_O & ~buf_rst_s; // RQ15

    // one level counter serves both sides; same-cycle accesses net out
    wire [AW:0] next_count = count + (AW+1)'(wr_do) - (AW+1)'(rd_do); // RQ5
    wire [AW:0] af_level = FULL_COUNT - (AW+1)'(af_ofs);

    wire next_empty_n = (next_count != '0);
    wire next_ae_n = (next_count > (AW+1)'(ae_ofs)); // RQ7
    wire next_full_n = (next_count != FULL_COUNT); // RQ6
    wire next_af_n = (next_count < af_level); // RQ7

    wire [`DCF_NUM_EV-1:0] events = {
        rd_edge & ALMOST_EMPTY_FLAG_N_O & ~next_ae_n & ~buf_rst_s,
        wr_edge & ALMOST_FULL_FLAG_N_O & ~next_af_n & ~buf_rst_s,
        rd_req & ~EMPTY_FLAG_N_O,
        wr_req & ~FULL_FLAG_N_O};

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            wclk_d <= 1'b0;
            rclk_d <= 1'b0;
        end else begin
            wclk_d <= wclk_s;
            rclk_d <= rclk_s;
        end
    end

    // level of enable b while the reset pin is low fixes the mode
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            mode <= DCF_MODE_DUAL_WE;
        end else if (buf_rst_s) begin
            mode <= wen_b_s ? DCF_MODE_DUAL_WE : DCF_MODE_OFS_LOAD; // RQ17
        end
    end

    // storage carries no reset; only the pointers define contents
    always_ff @(posedge REF_CLK_I) begin
        if (wr_do) begin
            mem[wr_ptr] <= data_s; // RQ3
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I || buf_rst_s) begin
            wr_ptr <= '0; // RQ16
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (wr_do) begin
                wr_ptr <= wr_ptr + AW'(1); // RQ2
            end
            if (rd_do) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            count <= next_count;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            DATA_O <= 9'h000;
        end else if (rd_do) begin
            DATA_O <= mem[rd_ptr]; // RQ3
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            DATA_OE_O <= 1'b0;
        end else begin
            DATA_OE_O <= ~oe_n_s; // RQ19
        end
    end

    // read-side flags: only a read clock edge or a reset may move them
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I || buf_rst_s) begin
            EMPTY_FLAG_N_O <= 1'b0; // RQ18
            ALMOST_EMPTY_FLAG_N_O <= 1'b0;
        end else if (rd_edge) begin
            EMPTY_FLAG_N_O <= next_empty_n; // RQ9
            ALMOST_EMPTY_FLAG_N_O <= next_ae_n; // RQ11
        end
    end

    // write-side flags: only a write clock edge or a reset may move them
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I || buf_rst_s) begin
            FULL_FLAG_N_O <= 1'b1; // RQ18
            ALMOST_FULL_FLAG_N_O <= 1'b1;
        end else if (wr_edge) begin
            FULL_FLAG_N_O <= next_full_n; // RQ10
            ALMOST_FULL_FLAG_N_O <= next_af_n; // RQ11
        end
    end

    // register slave: zero wait states, response always okay
    wire ahb_take = HSEL_I & HREADY_I & HTRANS_I[1];
    wire ahb_wr = ahb_take & HWRITE_I & (HSIZE_I == `DCF_HSIZE_WORD);
    wire ahb_rd = ahb_take & ~HWRITE_I;

    wire wr_ae = dp_write & (dp_addr == `DCF_ADDR_AE_OFS);
    wire wr_af = dp_write & (dp_addr == `DCF_ADDR_AF_OFS);
    wire wr_istat = dp_write & (dp_addr == `DCF_ADDR_IRQ_STAT);
    wire wr_imask = dp_write & (dp_addr == `DCF_ADDR_IRQ_MASK);

    wire [31:0] flags_word = 32'({
        mode == DCF_MODE_OFS_LOAD,
        ALMOST_FULL_FLAG_N_O,
        ALMOST_EMPTY_FLAG_N_O,
        FULL_FLAG_N_O,
        EMPTY_FLAG_N_O});

    wire [7:0] ra = HADDR_I[7:0];
    wire [31:0] rd_mux =
        (ra == `DCF_ADDR_AE_OFS) ? 32'(ae_ofs) :
        (ra == `DCF_ADDR_AF_OFS) ? 32'(af_ofs) :
        (ra == `DCF_ADDR_LEVEL) ? 32'(count) :
        (ra == `DCF_ADDR_FLAGS) ? flags_word :
        (ra == `DCF_ADDR_IRQ_STAT) ? 32'(irq_stat) :
        (ra == `DCF_ADDR_IRQ_MASK) ? 32'(irq_mask) :
        32'h0000_0000;

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_write <= ahb_wr;
            dp_addr <= HADDR_I[7:0];
        end
    end

    // read data sampled in the address phase; a read right after a
    // write to the same register sees the old value
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            HRDATA_O <= 32'h0000_0000;
        end else if (ahb_rd) begin
            HRDATA_O <= rd_mux;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end
    end

    // thresholds fall back to seven words on either reset
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I || buf_rst_s) begin
            ae_ofs <= OFS_RESET; // RQ8
            af_ofs <= OFS_RESET; // RQ8
        end else begin
            if (wr_ae) begin
                ae_ofs <= HWDATA_I[AW-1:0]; // RQ7
            end
            if (wr_af) begin
                af_ofs <= HWDATA_I[AW-1:0]; // RQ7
            end
        end
    end

    // sticky events: a new event beats a write-one clear
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            irq_stat <= '0;
            irq_mask <= '0;
            IRQ_O <= 1'b0;
        end else begin
            irq_stat <= (irq_stat &
                ~(wr_istat ? HWDATA_I[`DCF_NUM_EV-1:0] : '0)) | events;
            if (wr_imask) begin
                irq_mask <= HWDATA_I[`DCF_NUM_EV-1:0];
            end
            IRQ_O <= |(irq_stat & irq_mask);
        end
    end
endmodule // dcf_top

/* dcf_top_sva.sv */
// flag timing, output enable and bus response checks on dcf_top ports
// assumes pin clocks are slow: each phase spans at least two ref cycles
`timescale 1ns/1ps
module dcf_top_sva (
    input wire logic REF_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic WRITE_CLK_I,
    input wire logic READ_CLK_I,
    input wire logic BUFFER_RESET_N_I,
    input wire logic OUTPUT_ENABLE_N_I,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    input wire logic DATA_OE_O,
    input wire logic EMPTY_FLAG_N_O,
    input wire logic FULL_FLAG_N_O,
    input wire logic ALMOST_EMPTY_FLAG_N_O,
    input wire logic ALMOST_FULL_FLAG_N_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic [3:0] rd_age;
    logic [3:0] wr_age;
    logic [3:0] brst;
    logic quiet;
    // pin reset moves every flag at once, so edge checks rest meanwhile
    assign quiet = &brst;
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            rd_age <= 4'hF;
            wr_age <= 4'hF;
            brst <= 4'h0;
        end else begin
            rd_age <= $rose(READ_CLK_I) ? 4'h0 : rd_age + {3'h0, ~&rd_age};
            wr_age <= $rose(WRITE_CLK_I) ? 4'h0 : wr_age + {3'h0, ~&wr_age};
            brst <= {brst[2:0], BUFFER_RESET_N_I};
        end
    end
    sequence s_rd_recent;
        rd_age inside {[4'h0:4'h3]};
    endsequence
    sequence s_wr_recent;
        wr_age inside {[4'h0:4'h3]};
    endsequence
    a_empty_rd_edge: assert property (
        $changed(EMPTY_FLAG_N_O) && quiet |-> s_rd_recent)
        else $error("empty flag moved off a read clock edge");
    a_ae_rd_edge: assert property (
        $changed(ALMOST_EMPTY_FLAG_N_O) && quiet |-> s_rd_recent)
        else $error("almost-empty flag moved off a read clock edge");
    a_full_wr_edge: assert property (
        $changed(FULL_FLAG_N_O) && quiet |-> s_wr_recent)
        else $error("full flag moved off a write clock edge");
    a_af_wr_edge: assert property (
        $changed(ALMOST_FULL_FLAG_N_O) && quiet |-> s_wr_recent)
        else $error("almost-full flag moved off a write clock edge");
    a_empty_hold: assert property (
        $changed(EMPTY_FLAG_N_O) && quiet |=> $stable(EMPTY_FLAG_N_O)[*3])
        else $error("empty flag did not hold");
    a_full_hold: assert property (
        $changed(FULL_FLAG_N_O) && quiet |=> $stable(FULL_FLAG_N_O)[*3])
        else $error("full flag did not hold");
    a_full_has_af: assert property (
        !FULL_FLAG_N_O |-> !ALMOST_FULL_FLAG_N_O)
        else $error("full without almost-full");
    a_empty_has_ae: assert property (
        !EMPTY_FLAG_N_O |-> !ALMOST_EMPTY_FLAG_N_O && FULL_FLAG_N_O)
        else $error("empty without almost-empty or with full");
    // pin passes two sync stages and the output flop: three edges late
    a_oe_follow: assert property (
        !$past(SYS_RST_I) && !$past(SYS_RST_I, 2) && !$past(SYS_RST_I, 3)
        |-> DATA_OE_O == !$past(OUTPUT_ENABLE_N_I, 3))
        else $error("data output enable does not follow its pin");
    a_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
        else $error("bus slave stalled or answered with an error");
endmodule // dcf_top_sva

bind dcf_top dcf_top_sva u_dcf_top_sva (
    .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I),
    .WRITE_CLK_I(WRITE_CLK_I), .READ_CLK_I(READ_CLK_I),
    .BUFFER_RESET_N_I(BUFFER_RESET_N_I),
    .OUTPUT_ENABLE_N_I(OUTPUT_ENABLE_N_I),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .DATA_OE_O(DATA_OE_O),
    .EMPTY_FLAG_N_O(EMPTY_FLAG_N_O), .FULL_FLAG_N_O(FULL_FLAG_N_O),
    .ALMOST_EMPTY_FLAG_N_O(ALMOST_EMPTY_FLAG_N_O),
    .ALMOST_FULL_FLAG_N_O(ALMOST_FULL_FLAG_N_O));

/* dcf_pin_model.sv */
// producer and consumer behind the pin ports: free-running pin clocks
// assumes clk_i is the ref clock; one pin clock lasts 8 of its cycles
`timescale 1ns/1ps
module dcf_pin_model (
    input wire logic clk_i,
    input wire logic wr_req_i,
    input wire logic rd_req_i,
    input wire logic wen_b_i,
    output logic wclk_o,
    output logic rclk_o,
    output logic [8:0] data_o,
    output logic wen_a_n_o,
    output logic wen_b_o,
    output logic ren_n_o
);
    logic [2:0] ph;
    initial begin
        ph = 3'h0;
        {wclk_o, rclk_o, data_o} = '0;
        {wen_a_n_o, wen_b_o, ren_n_o} = 3'b111;
    end
    always @(posedge clk_i) begin
        ph <= ph + 3'h1;
        wclk_o <= ph[2];
        rclk_o <= ~ph[2];
        wen_b_o <= wen_b_i;
        // enables and data move half a pin clock away from its rise
        if (ph == 3'h0) begin
            data_o <= data_o + {8'h0, ~wen_a_n_o};
            wen_a_n_o <= ~wr_req_i;
        end
        if (ph == 3'h4)
            ren_n_o <= ~rd_req_i;
    end
endmodule // dcf_pin_model

/* dcf_top_tb.sv */
// self-checking bench: bus tasks and pin bursts through the pin model
// assumes dcf_top at 16 words and the pin model's 8-cycle pin clocks
`timescale 1ns/1ps
`include "dcf_regs.svh"
module dcf_top_tb;
    import dcf_pkg::*;
    logic REF_CLK_I, SYS_RST_I, HSEL_I, HWRITE_I, HREADY_I, HREADYOUT_O;
    logic HRESP_O, IRQ_O, WRITE_CLK_I, READ_CLK_I, READ_ENABLE_A_N_I;
    logic READ_ENABLE_B_N_I, WRITE_ENABLE_A_N_I, BUFFER_RESET_N_I;
    logic WRITE_ENABLE_B_OR_OFFSET_LOAD_I, OUTPUT_ENABLE_N_I, DATA_OE_O;
    logic EMPTY_FLAG_N_O, FULL_FLAG_N_O;
    logic ALMOST_EMPTY_FLAG_N_O, ALMOST_FULL_FLAG_N_O;
    logic [1:0] HTRANS_I;
    logic [2:0] HSIZE_I;
    logic [31:0] HADDR_I, HWDATA_I, HRDATA_O, rd;
    dcf_word_t DATA_I, DATA_O;
    logic wr_req, rd_req, wen_b;
    int err_count = 0;
    int comparisons = 0;
    assign HREADY_I = HREADYOUT_O;
    assign READ_ENABLE_B_N_I = READ_ENABLE_A_N_I;
    dcf_top #(.DEPTH(16)) u_dcf_top (
        .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .HSEL_I(HSEL_I),
        .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
        .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
        .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
        .IRQ_O(IRQ_O), .WRITE_CLK_I(WRITE_CLK_I), .READ_CLK_I(READ_CLK_I),
        .DATA_I(DATA_I), .WRITE_ENABLE_A_N_I(WRITE_ENABLE_A_N_I),
        .WRITE_ENABLE_B_OR_OFFSET_LOAD_I(WRITE_ENABLE_B_OR_OFFSET_LOAD_I),
        .READ_ENABLE_A_N_I(READ_ENABLE_A_N_I),
        .READ_ENABLE_B_N_I(READ_ENABLE_B_N_I),
        .BUFFER_RESET_N_I(BUFFER_RESET_N_I),
        .OUTPUT_ENABLE_N_I(OUTPUT_ENABLE_N_I),
        .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O),
        .EMPTY_FLAG_N_O(EMPTY_FLAG_N_O), .FULL_FLAG_N_O(FULL_FLAG_N_O),
        .ALMOST_EMPTY_FLAG_N_O(ALMOST_EMPTY_FLAG_N_O),
        .ALMOST_FULL_FLAG_N_O(ALMOST_FULL_FLAG_N_O));
    dcf_pin_model u_dcf_pin_model (
        .clk_i(REF_CLK_I), .wr_req_i(wr_req), .rd_req_i(rd_req),
        .wen_b_i(wen_b),
        .wclk_o(WRITE_CLK_I), .rclk_o(READ_CLK_I), .data_o(DATA_I),
        .wen_a_n_o(WRITE_ENABLE_A_N_I),
        .wen_b_o(WRITE_ENABLE_B_OR_OFFSET_LOAD_I),
        .ren_n_o(READ_ENABLE_A_N_I));
    initial begin
        REF_CLK_I = 1'b0;
        forever #20 REF_CLK_I = ~REF_CLK_I;
    end
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge REF_CLK_I);
        HTRANS_I <= 2'h2;
        HADDR_I <= {24'h0, a};
        HWRITE_I <= w;
        do @(posedge REF_CLK_I); while (HREADY_I !== 1'b1);
        HTRANS_I <= 2'h0;
        HWDATA_I <= d;
        do @(posedge REF_CLK_I); while (HREADY_I !== 1'b1);
        rd = HRDATA_O;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic fchk(input logic [3:0] e);
        chk({28'h0, ALMOST_FULL_FLAG_N_O, ALMOST_EMPTY_FLAG_N_O,
            FULL_FLAG_N_O, EMPTY_FLAG_N_O}, {28'h0, e});
    endtask
    // n words on back-to-back pin clocks; read data checked one clock on
    task automatic burst(input logic wr, input int n);
        for (int i = 0; i <= n + 1; i++) begin
            if (wr) @(posedge WRITE_CLK_I);
            else @(posedge READ_CLK_I);
            @(posedge REF_CLK_I);
            if (wr) wr_req <= (i < n);
            else rd_req <= (i < n);
            if (!wr && i > 1)
                chk({23'h0, DATA_O}, (i < 18) ? i - 2 : 15);
        end
    endtask
    initial begin
        {SYS_RST_I, HSEL_I, HWRITE_I, OUTPUT_ENABLE_N_I} = 4'b1100;
        {HTRANS_I, HADDR_I, HWDATA_I} = {2'h0, 64'h0};
        HSIZE_I = `DCF_HSIZE_WORD;
        {BUFFER_RESET_N_I, wr_req, rd_req, wen_b} = 4'b0001;
        repeat (8) @(posedge REF_CLK_I);
        SYS_RST_I <= 1'b0;
        repeat (4) @(posedge REF_CLK_I);
        BUFFER_RESET_N_I <= 1'b1;
        repeat (6) @(posedge REF_CLK_I);
        fchk(4'hA);
        rchk(`DCF_ADDR_AE_OFS, `DCF_OFS_DEFAULT);
        rchk(`DCF_ADDR_AF_OFS, `DCF_OFS_DEFAULT);
        rchk(8'h40, 32'h0);
        bus(1'b1, `DCF_ADDR_IRQ_MASK, 32'h1);
        burst(1'b1, 17);
        fchk(4'h5);
        rchk(`DCF_ADDR_LEVEL, 32'd16);
        chk({31'h0, IRQ_O}, 32'h1);
        rchk(`DCF_ADDR_IRQ_STAT, 32'h5);
        bus(1'b1, `DCF_ADDR_IRQ_STAT, 32'h5);
        bus(1'b1, `DCF_ADDR_AE_OFS, 32'h9);
        rchk(`DCF_ADDR_AE_OFS, 32'h9);
        burst(1'b0, 17);
        fchk(4'hA);
        rchk(`DCF_ADDR_IRQ_STAT, 32'hA);
        chk({31'h0, IRQ_O}, 32'h0);
        bus(1'b1, `DCF_ADDR_IRQ_MASK, 32'hA);
        rchk(`DCF_ADDR_IRQ_MASK, 32'hA);
        chk({31'h0, IRQ_O}, 32'h1);
        bus(1'b1, `DCF_ADDR_IRQ_STAT, 32'hF);
        rchk(`DCF_ADDR_IRQ_STAT, 32'h0);
        chk({31'h0, IRQ_O}, 32'h0);
        chk({31'h0, DATA_OE_O}, 32'h1);
        OUTPUT_ENABLE_N_I <= 1'b1;
        repeat (4) @(posedge REF_CLK_I);
        chk({31'h0, DATA_OE_O}, 32'h0);
        OUTPUT_ENABLE_N_I <= 1'b0;
        burst(1'b1, 3);
        rchk(`DCF_ADDR_LEVEL, 32'h3);
        // enable b low across the pin reset selects offset-load mode
        wen_b <= 1'b0;
        BUFFER_RESET_N_I <= 1'b0;
        repeat (6) @(posedge REF_CLK_I);
        BUFFER_RESET_N_I <= 1'b1;
        repeat (6) @(posedge REF_CLK_I);
        fchk(4'hA);
        rchk(`DCF_ADDR_LEVEL, 32'h0);
        rchk(`DCF_ADDR_AE_OFS, `DCF_OFS_DEFAULT);
        rchk(`DCF_ADDR_FLAGS, 32'h1A);
        wen_b <= 1'b1;
        BUFFER_RESET_N_I <= 1'b0;
        repeat (6) @(posedge REF_CLK_I);
        BUFFER_RESET_N_I <= 1'b1;
        repeat (6) @(posedge REF_CLK_I);
        rchk(`DCF_ADDR_FLAGS, 32'h0A);
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge REF_CLK_I);
        err_count++;
        $display("[FAIL] %0t watchdog ran out", $time);
        complete_run();
    end
endmodule // dcf_top_tb
